//--- hw/pulse_timer_pkg.sv
// ============================================================================
// pulse_timer_pkg: constants shared by the pulse output timer and its
// count source selector.
// assumes: single 25 MHz clock domain, synchronous active-low reset.
package pulse_timer_pkg;

  // ==========================================================================
  // widths
  localparam int unsigned COUNT_W = 8;
  localparam int unsigned SEL_W = 3;

  // ==========================================================================
  // count source select codes
  localparam logic [2:0] SEL_CLOCK_DIV1 = 3'h0;
  localparam logic [2:0] SEL_CLOCK_DIV2 = 3'h1;
  localparam logic [2:0] SEL_CLOCK_DIV8 = 3'h2;
  localparam logic [2:0] SEL_ONCHIP_OSC = 3'h3;
  localparam logic [2:0] SEL_SUBCLOCK_DIV32 = 3'h4;

  // ==========================================================================
  // divider terminal counts (counter runs 0..N-1)
  localparam logic [4:0] DIV2_LAST = 5'h01;
  localparam logic [4:0] DIV8_LAST = 5'h07;
  localparam logic [4:0] DIV32_LAST = 5'h1F;

  // ==========================================================================
  // values after reset; prescaler and timer values also after a forced stop
  localparam logic [7:0] PRESCALER_RESET = 8'hFF;
  localparam logic [7:0] TIMER_RESET = 8'hFF;
  localparam logic [2:0] SEL_RESET = 3'h0;

  // ==========================================================================
  // source selector state: gray coded along idle -> run
  typedef enum logic [1:0] {
    SRC_IDLE = 2'b00,
    SRC_RUN = 2'b01
  } src_state_t;

endpackage : pulse_timer_pkg

//--- hw/count_tick_if.sv
// ============================================================================
// count_tick_if: carries the count source selection and the resulting
// one-cycle count tick between the timer and its source selector.
// assumes: both ends on mclk.
`timescale 1ns/1ps
interface count_tick_if;
  logic [2:0] sel;
  logic run;
  logic tick;

  modport gen (
    input sel,
    input run,
    output tick
  );

  modport use_tick (
    output sel,
    output run,
    input tick
  );
endinterface : count_tick_if

//--- hw/count_source_sel.sv
// ============================================================================
// count_source_sel: turns the selected count source into a one-cycle tick
// on mclk.
// assumes: onchip_osc_clock and subclock arrive asynchronously as pins and
// are much slower than mclk/2.
`timescale 1ns/1ps
module count_source_sel
  import pulse_timer_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic onchip_osc_clock,
  input wire logic subclock,
  count_tick_if.gen cs
);

  logic [1:0] osc_sync_q;
  logic [1:0] sub_sync_q;
  logic osc_last_q;
  logic sub_last_q;
  logic [4:0] div_q;
  logic [4:0] sub_div_q;
  logic sub_tick_q;
  logic tick_q;
  src_state_t state_q;
  logic osc_rise;
  logic sub_rise;

  // ==========================================================================
  // pin synchronisers; stage 0 feeds stage 1 only
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      osc_sync_q <= 2'h0;
      sub_sync_q <= 2'h0;
      osc_last_q <= 1'b0;
      sub_last_q <= 1'b0;
    end else begin
      osc_sync_q <= {osc_sync_q[0], onchip_osc_clock};
      sub_sync_q <= {sub_sync_q[0], subclock};
      osc_last_q <= osc_sync_q[1];
      sub_last_q <= sub_sync_q[1];
    end
  end

  assign osc_rise = osc_sync_q[1] & ~osc_last_q;
  assign sub_rise = sub_sync_q[1] & ~sub_last_q;

  // dividers restart whenever counting is off so the first period is whole
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_q <= SRC_IDLE;
      div_q <= 5'h00;
      sub_div_q <= 5'h00;
      sub_tick_q <= 1'b0;
    end else begin
      state_q <= cs.run ? SRC_RUN : SRC_IDLE;
      sub_tick_q <= 1'b0;
      if (state_q == SRC_IDLE) begin
        div_q <= 5'h00;
        sub_div_q <= 5'h00;
      end else begin
        div_q <= (div_q == DIV8_LAST) ? 5'h00 : 5'(div_q + 5'h01);
        if (sub_rise) begin
          sub_div_q <= 5'(sub_div_q + 5'h01);
          sub_tick_q <= (sub_div_q == DIV32_LAST);
        end
      end
    end
  end

  // one of five internal sources becomes the tick
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      tick_q <= 1'b0;
    end else if (state_q != SRC_RUN || !cs.run) begin
      tick_q <= 1'b0;
    end else begin
      case (cs.sel)
        SEL_CLOCK_DIV1: tick_q <= 1'b1;
        SEL_CLOCK_DIV2: tick_q <= (div_q[0] == DIV2_LAST[0]);
        SEL_CLOCK_DIV8: tick_q <= (div_q[2:0] == DIV8_LAST[2:0]);
        SEL_ONCHIP_OSC: tick_q <= osc_rise;
        SEL_SUBCLOCK_DIV32: tick_q <= sub_tick_q;
        default: tick_q <= 1'b0;
      endcase
    end
  end

  assign cs.tick = tick_q;

endmodule : count_source_sel

//--- hw/pulse_output_timer.sv
// ============================================================================
// pulse_output_timer: 8-bit down counter behind an 8-bit prescaler, run in
// pulse output mode, toggling a pulse pin on each timer underflow that has no mode write in the same cycle.
// assumes: control writes arrive as one-cycle strobes on mclk; pins are
// asynchronous and resolved by the pad from value and enable.
//
// How it works
// - count source is clock/1, clock/2, clock/8, on-chip oscillator or subclock/32.
// - both counters decrement; timer underflow reloads both and counting continues.
// - underflow rate is source over (n+1)(m+1).
// - writing count start 1 starts counting.
// - writing count start 0 stops counting.
// - writing forced stop 1 halts counting at once.
// - each timer underflow raises the timer interrupt request.
// - pulse pin is pulse output, programmable output, or interrupt-one input.
// - inverted pin is a programmable port or inverse of pulse output.
// - reads return current counter values, not reload values.
// - while stopped, writes load reload register and counter together.
// - while counting, writes load reload register and later the counter.
// - start level select sets pulse level when generation begins.
// - inverted output enable drives complement of pulse on inverted pin.
// - pulse output stop stops pulse drive on the pulse pin.
// - pin location select routes pulse pin to port one bit seven or five.
// - writing the mode register restores the configured starting level.
// - a timer underflow without a mode write in the same cycle inverts the pulse pin level.
// - prescaler counts source cycles; timer counts prescaler underflows.
// - running, prescaler loads on source tick, timer loads on prescaler underflow.
// - forced stop sets prescaler and timer to all ones.
`timescale 1ns/1ps
module pulse_output_timer
  import pulse_timer_pkg::*;
#(
  parameter int unsigned WIDTH = COUNT_W
)
(
  input wire logic mclk,
  input wire logic reset_n,
  // count sources arriving as pins
  input wire logic onchip_osc_clock,
  input wire logic subclock,
  // timer control register write
  input wire logic timer_control_wr,
  input wire logic count_start_bit,
  input wire logic forced_stop_bit,
  // mode register write, carrying the count source select
  input wire logic mode_wr,
  input wire logic [2:0] count_source_select,
  // prescaler and timer register writes
  input wire logic prescaler_wr,
  input wire logic timer_wr,
  input wire logic [WIDTH-1:0] wr_data,
  // io control register bits, held as levels
  input wire logic start_level_select,
  input wire logic inverted_out_enable,
  input wire logic pulse_output_stop,
  input wire logic pin_location_select,
  // programmable port data and direction for the three pins
  input wire logic port_one_bit_seven_data,
  input wire logic port_one_bit_seven_dir,
  input wire logic port_one_bit_five_data,
  input wire logic port_one_bit_five_dir,
  input wire logic inverted_port_data,
  input wire logic inverted_port_dir,
  // pins
  input wire logic port_one_bit_seven_in,
  output logic port_one_bit_seven_out,
  output logic port_one_bit_seven_oe,
  input wire logic port_one_bit_five_in,
  output logic port_one_bit_five_out,
  output logic port_one_bit_five_oe,
  output logic inverted_out_pin_out,
  output logic inverted_out_pin_oe,
  // status
  output logic [WIDTH-1:0] prescaler_count,
  output logic [WIDTH-1:0] timer_count,
  output logic count_active,
  output logic pulse_level,
  output logic external_irq_one_input,
  output logic timer_irq
);

  // ==========================================================================
  // storage
  logic active_q;
  logic [2:0] sel_q;
  logic [WIDTH-1:0] pre_reload_q;
  logic [WIDTH-1:0] tmr_reload_q;
  logic [WIDTH-1:0] pre_cnt_q;
  logic [WIDTH-1:0] tmr_cnt_q;
  logic pre_pend_q;
  logic tmr_pend_q;
  logic level_q;
  logic irq_q;
  logic [1:0] p17_sync_q;
  logic [1:0] p15_sync_q;
  logic irq_one_q;
  logic p17_out_q;
  logic p17_oe_q;
  logic p15_out_q;
  logic p15_oe_q;
  logic inv_out_q;
  logic inv_oe_q;
  logic tick;
  logic pre_uf;
  logic tmr_uf;
  logic start_req;
  logic stop_req;
  logic force_req;

  count_tick_if cs_bus ();

  // ==========================================================================
  // reload-or-decrement step shared by both counters
  function automatic logic [WIDTH-1:0] step_count(
    input logic [WIDTH-1:0] cnt,
    input logic [WIDTH-1:0] reload
  );
    step_count = (cnt == '0) ? reload : WIDTH'(cnt - 1'b1);
  endfunction : step_count

  // ==========================================================================
  // count source
  assign cs_bus.sel = sel_q;
  assign cs_bus.run = active_q;
  assign tick = cs_bus.tick;

  count_source_sel u_src (
    .mclk(mclk),
    .reset_n(reset_n),
    .onchip_osc_clock(onchip_osc_clock),
    .subclock(subclock),
    .cs(cs_bus.gen)
  );

  // ==========================================================================
  // control decode
  assign force_req = timer_control_wr & forced_stop_bit;
  assign start_req = timer_control_wr & count_start_bit & ~forced_stop_bit;
  assign stop_req = timer_control_wr & ~count_start_bit & ~forced_stop_bit;

  // underflows only count while running; a tick after a stop is dropped
  assign pre_uf = active_q & tick & ~pre_pend_q & (pre_cnt_q == '0);
  assign tmr_uf = pre_uf & ~tmr_pend_q & (tmr_cnt_q == '0);

  // run flag; forced stop wins over a start in the same write
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      active_q <= 1'b0;
    end else if (force_req) begin
      active_q <= 1'b0;
    end else if (start_req) begin
      active_q <= 1'b1;
    end else if (stop_req) begin
      active_q <= 1'b0;
    end
  end

  // source select is taken from the mode register
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sel_q <= SEL_RESET;
    end else if (mode_wr) begin
      sel_q <= count_source_select;
    end
  end

  // ==========================================================================
  // reload registers
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pre_reload_q <= PRESCALER_RESET;
      tmr_reload_q <= TIMER_RESET;
    end else if (force_req) begin
      pre_reload_q <= PRESCALER_RESET;
      tmr_reload_q <= TIMER_RESET;
    end else begin
      if (prescaler_wr) begin
        pre_reload_q <= wr_data;
      end
      if (timer_wr) begin
        tmr_reload_q <= wr_data;
      end
    end
  end

  // ==========================================================================
  // prescaler counter; a write while running waits for the next tick
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pre_cnt_q <= PRESCALER_RESET;
      pre_pend_q <= 1'b0;
    end else if (force_req) begin
      pre_cnt_q <= PRESCALER_RESET;
      pre_pend_q <= 1'b0;
    end else begin
      if (active_q && tick) begin
        if (pre_pend_q) begin
          pre_cnt_q <= pre_reload_q;
        end else begin
          pre_cnt_q <= step_count(pre_cnt_q, pre_reload_q);
        end
      end
      if (active_q && tick) begin
        pre_pend_q <= 1'b0;
      end
      // a fresh write wins over the pending transfer being consumed
      if (prescaler_wr) begin
        if (active_q) begin
          pre_pend_q <= 1'b1;
        end else begin
          pre_cnt_q <= wr_data;
          pre_pend_q <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // timer counter; steps on prescaler underflow only
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      tmr_cnt_q <= TIMER_RESET;
      tmr_pend_q <= 1'b0;
    end else if (force_req) begin
      tmr_cnt_q <= TIMER_RESET;
      tmr_pend_q <= 1'b0;
    end else begin
      if (pre_uf) begin
        if (tmr_pend_q) begin
          tmr_cnt_q <= tmr_reload_q;
        end else begin
          tmr_cnt_q <= step_count(tmr_cnt_q, tmr_reload_q);
        end
        tmr_pend_q <= 1'b0;
      end
      if (timer_wr) begin
        if (active_q) begin
          tmr_pend_q <= 1'b1;
        end else begin
          tmr_cnt_q <= wr_data;
          tmr_pend_q <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // interrupt pulse, one mclk wide per underflow
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= tmr_uf;
    end
  end

  // ==========================================================================
  // pulse level; a mode write or a start from stop restores the start level
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      level_q <= 1'b0;
    end else if (mode_wr) begin
      level_q <= start_level_select;
    end else if (start_req && !active_q) begin
      level_q <= start_level_select;
    end else if (tmr_uf) begin
      level_q <= ~level_q;
    end
  end

  // ==========================================================================
  // pin routing, registered so pads see no decode glitches
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      p17_out_q <= 1'b0;
      p17_oe_q <= 1'b0;
      p15_out_q <= 1'b0;
      p15_oe_q <= 1'b0;
    end else begin
      p17_out_q <= port_one_bit_seven_data;
      p17_oe_q <= port_one_bit_seven_dir;
      p15_out_q <= port_one_bit_five_data;
      p15_oe_q <= port_one_bit_five_dir;
      // pulse drive only on the selected pin and only when not stopped
      if (!pulse_output_stop) begin
        if (pin_location_select) begin
          p15_out_q <= level_q;
          p15_oe_q <= 1'b1;
        end else begin
          p17_out_q <= level_q;
          p17_oe_q <= 1'b1;
        end
      end
    end
  end

  // inverted pin follows the complement of the pulse level when enabled
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      inv_out_q <= 1'b0;
      inv_oe_q <= 1'b0;
    end else if (inverted_out_enable) begin
      inv_out_q <= ~level_q;
      inv_oe_q <= 1'b1;
    end else begin
      inv_out_q <= inverted_port_data;
      inv_oe_q <= inverted_port_dir;
    end
  end

  // ==========================================================================
  // interrupt-one input from the selected location, synchronised first
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      p17_sync_q <= 2'h0;
      p15_sync_q <= 2'h0;
      irq_one_q <= 1'b0;
    end else begin
      p17_sync_q <= {p17_sync_q[0], port_one_bit_seven_in};
      p15_sync_q <= {p15_sync_q[0], port_one_bit_five_in};
      irq_one_q <= pin_location_select ? p15_sync_q[1] : p17_sync_q[1];
    end
  end

  // ==========================================================================
  // outputs
  assign port_one_bit_seven_out = p17_out_q;
  assign port_one_bit_seven_oe = p17_oe_q;
  assign port_one_bit_five_out = p15_out_q;
  assign port_one_bit_five_oe = p15_oe_q;
  assign inverted_out_pin_out = inv_out_q;
  assign inverted_out_pin_oe = inv_oe_q;
  assign prescaler_count = pre_cnt_q;
  assign timer_count = tmr_cnt_q;
  assign count_active = active_q;
  assign pulse_level = level_q;
  assign external_irq_one_input = irq_one_q;
  assign timer_irq = irq_q;

endmodule : pulse_output_timer

//--- bench/pulse_output_timer_properties.sv
// ============================================================================
// pulse_output_timer checker: port relations of the pulse output timer.
// assumes: bound into pulse_output_timer, one mclk domain, sync low reset.
`timescale 1ns/1ps
module pulse_output_timer_chk
  import pulse_timer_pkg::*;
#(
  parameter int unsigned WIDTH = COUNT_W
)
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic timer_control_wr,
  input wire logic count_start_bit,
  input wire logic forced_stop_bit,
  input wire logic mode_wr,
  input wire logic prescaler_wr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic start_level_select,
  input wire logic inverted_out_enable,
  input wire logic pulse_output_stop,
  input wire logic pin_location_select,
  input wire logic port_one_bit_seven_data,
  input wire logic port_one_bit_seven_out,
  input wire logic port_one_bit_seven_oe,
  input wire logic port_one_bit_five_out,
  input wire logic port_one_bit_five_oe,
  input wire logic inverted_out_pin_out,
  input wire logic inverted_out_pin_oe,
  input wire logic [WIDTH-1:0] prescaler_count,
  input wire logic [WIDTH-1:0] timer_count,
  input wire logic count_active,
  input wire logic pulse_level,
  input wire logic timer_irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // ==========================================================================
  // control write steps
  sequence s_force;
    timer_control_wr && forced_stop_bit;
  endsequence
  sequence s_start;
    timer_control_wr && count_start_bit && !forced_stop_bit;
  endsequence

  // ==========================================================================
  // counting and control
  chk_force_ones: assert property (s_force |=> !count_active
    && prescaler_count == 8'hFF && timer_count == 8'hFF)
    else $error("forced stop left counters or run flag wrong");
  chk_start_runs: assert property (s_start |=> count_active)
    else $error("start write did not start counting");
  chk_stop_halts: assert property (timer_control_wr && !count_start_bit |=> !count_active)
    else $error("stop write did not stop counting");
  chk_stopped_load: assert property (!count_active && prescaler_wr && !timer_control_wr
    |=> prescaler_count == $past(wr_data))
    else $error("stopped write did not reach the prescaler counter");
  chk_irq_one_cycle: assert property (timer_irq |=> !timer_irq)
    else $error("interrupt request longer than one cycle");
  chk_irq_toggle: assert property (timer_irq |-> pulse_level != $past(pulse_level))
    else $error("underflow without pulse level inversion");
  chk_mode_level: assert property (mode_wr && !count_active
    |=> pulse_level == $past(start_level_select))
    else $error("mode write did not restore the start level");

  // ==========================================================================
  // pins: outputs lag the internal level by one register stage
  chk_inv_drive: assert property ($past(reset_n && inverted_out_enable)
    |-> inverted_out_pin_oe && inverted_out_pin_out != $past(pulse_level))
    else $error("inverted pin not the complement of the pulse");
  chk_seven_route: assert property ($past(reset_n && !pulse_output_stop && !pin_location_select)
    |-> port_one_bit_seven_oe && port_one_bit_seven_out == $past(pulse_level))
    else $error("pulse not routed to port one bit seven");
  chk_five_route: assert property ($past(reset_n && !pulse_output_stop && pin_location_select)
    |-> port_one_bit_five_oe && port_one_bit_five_out == $past(pulse_level))
    else $error("pulse not routed to port one bit five");
  chk_port_hold: assert property ($past(reset_n && pulse_output_stop)
    |-> port_one_bit_seven_out == $past(port_one_bit_seven_data))
    else $error("stopped pulse pin does not show port data");
endmodule : pulse_output_timer_chk

bind pulse_output_timer pulse_output_timer_chk #(.WIDTH(WIDTH)) i_chk (.mclk(mclk),
  .reset_n(reset_n), .timer_control_wr(timer_control_wr), .count_start_bit(count_start_bit),
  .forced_stop_bit(forced_stop_bit), .mode_wr(mode_wr), .prescaler_wr(prescaler_wr),
  .wr_data(wr_data), .start_level_select(start_level_select),
  .inverted_out_enable(inverted_out_enable), .pulse_output_stop(pulse_output_stop),
  .pin_location_select(pin_location_select),
  .port_one_bit_seven_data(port_one_bit_seven_data),
  .port_one_bit_seven_out(port_one_bit_seven_out), .port_one_bit_seven_oe(port_one_bit_seven_oe),
  .port_one_bit_five_out(port_one_bit_five_out), .port_one_bit_five_oe(port_one_bit_five_oe),
  .inverted_out_pin_out(inverted_out_pin_out), .inverted_out_pin_oe(inverted_out_pin_oe),
  .prescaler_count(prescaler_count), .timer_count(timer_count), .count_active(count_active),
  .pulse_level(pulse_level), .timer_irq(timer_irq));

//--- bench/pulse_pin_load.sv
// ============================================================================
// pulse_pin_load: circuit hung on the timer pins, weakly pulling to ext_level.
// assumes: pin out and enable come from the timer's registers.
`timescale 1ns/1ps
module pulse_pin_load (
  input wire logic mclk,
  input wire logic ext_level,
  input wire logic seven_out,
  input wire logic seven_oe,
  input wire logic five_out,
  input wire logic five_oe,
  input wire logic inv_out,
  input wire logic inv_oe,
  output logic seven_wire,
  output logic five_wire,
  output logic inv_wire,
  output int seven_edges,
  output int five_edges
);
  logic seven_prev = 1'b0;
  logic five_prev = 1'b0;
  // a released pin shows the load level, never the last driven value
  assign seven_wire = seven_oe ? seven_out : ext_level;
  assign five_wire = five_oe ? five_out : ext_level;
  assign inv_wire = inv_oe ? inv_out : ext_level;
  // edges counted on the falling edge, away from the timer's updates
  initial begin
    seven_edges = 0;
    five_edges = 0;
  end
  always @(negedge mclk) begin
    seven_edges <= seven_edges + int'(seven_wire != seven_prev);
    five_edges <= five_edges + int'(five_wire != five_prev);
    seven_prev <= seven_wire;
    five_prev <= five_wire;
  end
endmodule : pulse_pin_load

//--- bench/tb_pulse_output_timer.sv
// ============================================================================
// tb_pulse_output_timer: control strobes, period and pin checks of the timer.
// assumes: pulse_pin_load on the pins, checker attached by bind.
`timescale 1ns/1ps
module tb_pulse_output_timer;
  import pulse_timer_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic onchip_osc_clock = 1'b0;
  logic subclock = 1'b0;
  logic timer_control_wr = 1'b0, count_start_bit = 1'b0, forced_stop_bit = 1'b0;
  logic mode_wr = 1'b0, prescaler_wr = 1'b0, timer_wr = 1'b0;
  logic [2:0] count_source_select = 3'h0;
  logic [7:0] wr_data = 8'h00;
  logic start_level_select = 1'b0, inverted_out_enable = 1'b0;
  logic pulse_output_stop = 1'b0, pin_location_select = 1'b0;
  logic port_one_bit_seven_data = 1'b0, port_one_bit_seven_dir = 1'b0;
  logic port_one_bit_five_data = 1'b0, port_one_bit_five_dir = 1'b0;
  logic inverted_port_data = 1'b0, inverted_port_dir = 1'b0, ext_level = 1'b1;
  logic port_one_bit_seven_in, port_one_bit_seven_out, port_one_bit_seven_oe;
  logic port_one_bit_five_in, port_one_bit_five_out, port_one_bit_five_oe;
  logic inverted_out_pin_out, inverted_out_pin_oe, inv_wire;
  logic [7:0] prescaler_count, timer_count, p0;
  logic count_active, pulse_level, external_irq_one_input, timer_irq;
  int seven_edges, five_edges, cyc, e0;
  int n_fail = 0, n_tests = 0, cycles = 0;
  int mult [5] = '{1, 2, 8, 10, 256};

  // ==========================================================================
  // clocks: slow sources are whole multiples of mclk so periods come out exact
  always #20 mclk = ~mclk;
  always #200 onchip_osc_clock = ~onchip_osc_clock;
  always #160 subclock = ~subclock;

  pulse_output_timer i_dut (.*);

  pulse_pin_load i_load (.mclk, .ext_level, .seven_out(port_one_bit_seven_out),
    .seven_oe(port_one_bit_seven_oe), .five_out(port_one_bit_five_out),
    .five_oe(port_one_bit_five_oe), .inv_out(inverted_out_pin_out), .inv_oe(inverted_out_pin_oe),
    .seven_wire(port_one_bit_seven_in), .five_wire(port_one_bit_five_in), .inv_wire,
    .seven_edges, .five_edges);

  // ==========================================================================
  // tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one-cycle strobe: 0 control, 1 mode, 2 prescaler, 3 timer
  task automatic strobe(input int which, input logic [7:0] d);
    @(negedge mclk);
    wr_data = d;
    timer_control_wr = (which == 0);
    mode_wr = (which == 1);
    prescaler_wr = (which == 2);
    timer_wr = (which == 3);
    @(negedge mclk);
    {timer_control_wr, mode_wr, prescaler_wr, timer_wr} = 4'h0;
  endtask : strobe

  task automatic wr_ctl(input logic s, input logic f);
    count_start_bit = s;
    forced_stop_bit = f;
    strobe(0, 8'h00);
  endtask : wr_ctl

  // stop, select source and level, load counters
  task automatic setup(input logic [2:0] sel, input logic lv, input logic [7:0] n,
    input logic [7:0] m);
    wr_ctl(1'b0, 1'b0);
    count_source_select = sel;
    start_level_select = lv;
    strobe(1, 8'h00);
    strobe(2, n);
    strobe(3, m);
    check("pre load", prescaler_count, n);
    check("tim load", timer_count, m);
  endtask : setup

  // bounded wait for a request, then cycles to the next one
  task automatic period(output int c);
    int k;
    k = 0;
    while (timer_irq !== 1'b1 && k < 5000) begin
      @(negedge mclk);
      k++;
    end
    c = 0;
    do begin
      @(negedge mclk);
      c++;
    end while (timer_irq !== 1'b1 && c < 5000);
  endtask : period

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================================
  // hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      n_fail++;
      $display("BAD timeout expected finish seen hang");
      wrap_up();
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    repeat (3) @(negedge mclk);
    reset_n = 1'b1;
    check("pre reset", prescaler_count, 8'hFF);
    check("tim reset", timer_count, 8'hFF);
    for (int i = 0; i < 5; i++) begin
      setup(i[2:0], i[0], 8'h02, 8'h03);
      check("start level", pulse_level, i[0]);
      wr_ctl(1'b1, 1'b0);
      period(cyc);
      check("period", cyc, 12 * mult[i]);
    end
    setup(SEL_CLOCK_DIV1, 1'b0, 8'h02, 8'h03);
    wr_ctl(1'b1, 1'b0);
    repeat (4) @(negedge mclk);
    p0 = prescaler_count;
    @(negedge mclk);
    check("pre step", prescaler_count, (p0 == 8'h00) ? 8'h02 : p0 - 8'h01);
    strobe(3, 8'h01);
    period(cyc);
    period(cyc);
    check("new period", cyc, 16'd6);
    inverted_out_enable = 1'b1;
    inverted_port_dir = 1'b1;
    port_one_bit_five_dir = 1'b1;
    repeat (2) @(negedge mclk);
    e0 = seven_edges;
    repeat (60) @(negedge mclk);
    check("seven edges", seven_edges - e0, 16'd10);
    check("inverted", inv_wire, !port_one_bit_seven_in);
    check("five port", port_one_bit_five_in, 1'b0);
    pin_location_select = 1'b1;
    repeat (2) @(negedge mclk);
    e0 = five_edges;
    repeat (60) @(negedge mclk);
    check("five edges", five_edges - e0, 16'd10);
    check("seven released", port_one_bit_seven_in, 1'b1);
    pulse_output_stop = 1'b1;
    port_one_bit_five_dir = 1'b0;
    inverted_out_enable = 1'b0;
    inverted_port_data = 1'b0;
    for (int v = 0; v < 2; v++) begin
      ext_level = v[0];
      repeat (5) @(negedge mclk);
      check("five stopped", port_one_bit_five_in, v[0]);
      check("irq one input", external_irq_one_input, v[0]);
    end
    check("inv port", inv_wire, 1'b0);
    wr_ctl(1'b0, 1'b0);
    p0 = timer_count;
    repeat (20) @(negedge mclk);
    check("stopped tim", timer_count, p0);
    wr_ctl(1'b1, 1'b0);
    repeat (5) @(negedge mclk);
    wr_ctl(1'b1, 1'b1);
    check("forced pre", prescaler_count, 8'hFF);
    check("forced tim", timer_count, 8'hFF);
    check("forced run", count_active, 1'b0);
    wrap_up();
  end
endmodule : tb_pulse_output_timer
